/* File: hdl/rup_pkg.sv */
// constants and types shared by the remote update initiator packet block
package rup_pkg;

    // frame header fields
    localparam logic [47:0] DEST_ADDR    = 48'hFFFF_FFFF_FFFF;
    localparam logic [15:0] ETHER_TYPE   = 16'h0700;
    localparam logic [15:0] LEN_CTRL     = 16'h0040;
    localparam logic [15:0] LEN_DATA     = 16'h0400;
    localparam logic [15:0] OFFSET_VALUE = 16'h0000;
    localparam logic [31:0] ZERO_FIELD   = 32'h0000_0000;

    // command codes sent toward the target
    localparam logic [15:0] CMD_CTRL     = 16'h0004;
    localparam logic [15:0] CMD_PAYLOAD  = 16'h0005;
    localparam logic [15:0] CMD_AUTH     = 16'h0007;
    localparam logic [15:0] CMD_PROG     = 16'h0008;
    localparam logic [15:0] CMD_VERSION  = 16'h0009;
    localparam logic [15:0] CMD_CLEAR    = 16'h000A;

    // command codes returned by the target
    localparam logic [15:0] RSP_WRITE_DONE = 16'h0001;
    localparam logic [15:0] RSP_AUTH_DONE  = 16'h0002;
    localparam logic [15:0] RSP_VERSION    = 16'h0003;
    localparam logic [15:0] RSP_XFER_ACK   = 16'h0004;
    localparam logic [15:0] RSP_AUTH_DONE2 = 16'h0006;

    // word positions inside a frame (64-bit words, first byte in bits 63:56)
    localparam logic [7:0] WORD_TYPE      = 8'h01;
    localparam logic [7:0] WORD_PAY_FIRST = 8'h03;
    localparam logic [7:0] WORD_CTRL_LAST = 8'h0A;
    localparam logic [7:0] WORD_DATA_LAST = 8'h82;

    // user command codes on the serial write port
    localparam logic [7:0] UCMD_XFER    = 8'h01;
    localparam logic [7:0] UCMD_VERSION = 8'h02;
    localparam logic [7:0] UCMD_AUTH    = 8'h03;
    localparam logic [7:0] UCMD_PROG    = 8'h04;
    localparam logic [7:0] UCMD_CLEAR   = 8'h05;

    // status read selects on the serial read port
    localparam logic [1:0] RSEL_XFER    = 2'h0;
    localparam logic [1:0] RSEL_AUTH    = 2'h1;
    localparam logic [1:0] RSEL_PKTNUM  = 2'h2;
    localparam logic [1:0] RSEL_VERSION = 2'h3;

    // request resend interval
    localparam int          CLK_MHZ      = 100;
    localparam int          RETRY_NS     = 10000;
    localparam logic [11:0] RETRY_CYCLES = 12'(RETRY_NS * CLK_MHZ / 1000);

    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT_ACK} rup_state_t;
    typedef enum logic [2:0] {PH_REQ, PH_DATA0, PH_DATA1, PH_LAST, PH_CMD} rup_phase_t;

endpackage

/* File: hdl/rup_initiator.sv */
// remote update initiator: command store, frame generator, reply parser, serial front end
`timescale 1ns/100ps

module rup_initiator
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // serial port core side
    input  wire logic        ser_wr_valid,
    input  wire logic [7:0]  ser_wr_data,
    input  wire logic        ser_rd_req,
    input  wire logic [1:0]  ser_rd_sel,
    output logic             ser_rd_valid,
    output logic [31:0]      ser_rd_data,
    // soft processor side
    output logic [4:0]       cmd_irq,
    input  wire logic        buf_wr_en,
    input  wire logic [7:0]  buf_wr_addr,
    input  wire logic [63:0] buf_wr_data,
    input  wire logic        chunk_ready,
    input  wire logic        chunk_last,
    input  wire logic [15:0] last_size,
    output logic             chunk_done,
    input  wire logic [47:0] mac_addr,
    // transmit stream toward the MAC
    output logic             tx_valid,
    output logic [63:0]      tx_data,
    output logic             tx_sop,
    output logic             tx_eop,
    input  wire logic        tx_ready,
    // receive stream from the MAC
    input  wire logic        rx_valid,
    input  wire logic [63:0] rx_data,
    input  wire logic        rx_sop,
    input  wire logic        rx_eop
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        rup_pkg::rup_state_t   st;
        rup_pkg::rup_phase_t   phase;
        logic [15:0]           pk_cmd;
        logic                  pk_data;
        logic                  pk_half;
        logic [63:0]           pk_w0;
        logic [7:0]            widx;
        logic [11:0]           retry;
        logic [4:0]            pend;
        logic                  ack;
        logic                  last_r;
        logic [15:0]           size_r;
        logic [1:0][65:0]      fifo;
        logic [1:0]            f_cnt;
        logic                  f_wr;
        logic                  f_rd;
        logic [255:0][63:0]    mem;
        logic [7:0]            rx_idx;
        logic                  rx_ok;
        logic [15:0]           rx_cmd;
        logic [63:0]           rx_pay;
        logic                  xfer_done;
        logic                  auth_done;
        logic [15:0]           auth_err;
        logic [31:0]           version;
        logic [15:0]           pkt_num;
        logic                  rd_valid;
        logic [31:0]           rd_data;
        logic [4:0]            irq;
        logic                  done_p;
    } rup_regs_t;

    rup_regs_t r;
    rup_regs_t r_nxt;

    localparam logic [11:0] RUP_RETRY_LAST = rup_pkg::RETRY_CYCLES - 12'h001;

    ////////////////////////////////////////////////////////////////////////////////
    // prime the state for a new frame
    function automatic rup_regs_t launch(input rup_regs_t s, input logic [15:0] cmd,
                                         input logic dat, input logic half,
                                         input logic [63:0] w0, input rup_pkg::rup_phase_t ph);
        rup_regs_t t;
        t         = s;
        t.st      = rup_pkg::ST_SEND;
        t.pk_cmd  = cmd;
        t.pk_data = dat;
        t.pk_half = half;
        t.pk_w0   = w0;
        t.phase   = ph;
        t.widx    = 8'h00;
        return t;
    endfunction

    // frame word generator
    function automatic logic [63:0] frame_word(input rup_regs_t s, input logic [47:0] mac);
        logic [63:0] w;
        logic [7:0]  maddr;
        w     = 64'h0000_0000_0000_0000;
        maddr = {s.pk_half, 7'(s.widx - rup_pkg::WORD_PAY_FIRST)};
        case (s.widx)
            8'h00:
            begin
                w = {rup_pkg::DEST_ADDR, mac[47:32]};
            end
            8'h01:
            begin
                w = {mac[31:0], rup_pkg::ETHER_TYPE, s.pk_cmd};
            end
            8'h02:
            begin
                w = {rup_pkg::ZERO_FIELD, s.pk_data ? rup_pkg::LEN_DATA : rup_pkg::LEN_CTRL,
                     rup_pkg::OFFSET_VALUE};
            end
            default:
            begin
                if (s.pk_data)
                begin
                    w = s.mem[maddr];
                end
                // first control payload word, rest zero
                else if (s.widx == rup_pkg::WORD_PAY_FIRST)
                begin
                    w = s.pk_w0;
                end
            end
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic        push;
        logic        pop;
        logic        fin;
        logic        ack_set;
        logic        ack_clr;
        logic [4:0]  pend_set;
        logic [4:0]  pend_clr;
        logic [7:0]  rcur;
        logic [63:0] w0_auth;
        logic        wd_set;
        logic        ad_set;
        push     = 1'b0;
        wd_set   = 1'b0;
        ad_set   = 1'b0;
        pop      = 1'b0;
        fin      = 1'b0;
        ack_set  = 1'b0;
        ack_clr  = 1'b0;
        pend_set = 5'h00;
        pend_clr = 5'h00;
        rcur     = rx_sop ? 8'h00 : r.rx_idx;
        r_nxt    = r;
        r_nxt.irq      = 5'h00;
        r_nxt.done_p   = 1'b0;
        r_nxt.rd_valid = 1'b0;
        w0_auth  = {16'h0000, r.size_r, 31'h0000_0000, r.last_r};

        if (buf_wr_en)
        begin
            r_nxt.mem[buf_wr_addr] = buf_wr_data;
        end

        if (ser_wr_valid)
        begin
            case (ser_wr_data)
                rup_pkg::UCMD_XFER:    r_nxt.irq = 5'h01;
                rup_pkg::UCMD_VERSION: begin r_nxt.irq = 5'h02; pend_set = 5'h02; end
                rup_pkg::UCMD_AUTH:    begin r_nxt.irq = 5'h04; pend_set = 5'h04; end
                rup_pkg::UCMD_PROG:    begin r_nxt.irq = 5'h08; pend_set = 5'h08; end
                rup_pkg::UCMD_CLEAR:   begin r_nxt.irq = 5'h10; pend_set = 5'h10; end
                default:               r_nxt.irq = 5'h00;
            endcase
        end
        if (chunk_ready)
        begin
            pend_set[0]  = 1'b1;
            r_nxt.last_r = chunk_last;
            r_nxt.size_r = last_size;
        end

        // status only on a read request
        if (ser_rd_req)
        begin
            r_nxt.rd_valid = 1'b1;
            case (ser_rd_sel)
                rup_pkg::RSEL_XFER:    r_nxt.rd_data = {31'h0000_0000, r.xfer_done};
                rup_pkg::RSEL_AUTH:    r_nxt.rd_data = {r.auth_err, 15'h0000, r.auth_done};
                rup_pkg::RSEL_PKTNUM:  r_nxt.rd_data = {16'h0000, r.pkt_num};
                default:               r_nxt.rd_data = r.version;
            endcase
        end

        if (rx_valid)
        begin
            r_nxt.rx_idx = (rcur == 8'hFF) ? rcur : 8'(rcur + 8'h01);
            if (rcur == rup_pkg::WORD_TYPE)
            begin
                // only the reserved type is accepted
                r_nxt.rx_ok  = (rx_data[31:16] == rup_pkg::ETHER_TYPE);
                r_nxt.rx_cmd = rx_data[15:0];
            end
            if (rcur == rup_pkg::WORD_PAY_FIRST)
            begin
                r_nxt.rx_pay = rx_data;
            end
            if (rx_eop && r.rx_ok && rcur > rup_pkg::WORD_TYPE)
            begin
                r_nxt.rx_ok = 1'b0;
                case (r.rx_cmd)
                    rup_pkg::RSP_XFER_ACK:   ack_set = 1'b1;
                    rup_pkg::RSP_WRITE_DONE: wd_set = 1'b1;
                    rup_pkg::RSP_AUTH_DONE, rup_pkg::RSP_AUTH_DONE2:
                    begin
                        ad_set = 1'b1;
                        r_nxt.auth_err  = (rcur == rup_pkg::WORD_PAY_FIRST) ?
                                          rx_data[15:0] : r.rx_pay[15:0];
                        r_nxt.version   = (rcur == rup_pkg::WORD_PAY_FIRST) ?
                                          rx_data[63:32] : r.rx_pay[63:32];
                    end
                    rup_pkg::RSP_VERSION:
                    begin
                        r_nxt.version = (rcur == rup_pkg::WORD_PAY_FIRST) ?
                                        rx_data[63:32] : r.rx_pay[63:32];
                    end
                    default: r_nxt.rx_ok = 1'b0;
                endcase
            end
        end

        // two-entry output buffer, drained by the MAC
        pop = tx_ready && (r.f_cnt != 2'h0);
        if (pop)
        begin
            r_nxt.f_rd = ~r.f_rd;
        end

        // command store and generator
        case (r.st)
            rup_pkg::ST_IDLE:
            begin
                // chunk opens with a transfer request
                if (r.pend[0])
                begin
                    pend_clr[0] = 1'b1;
                    ack_clr     = 1'b1;
                    r_nxt = launch(r_nxt, rup_pkg::CMD_CTRL, 1'b0, 1'b0, 64'h0,
                                   rup_pkg::PH_REQ);
                end
                else if (r.pend[1])
                begin
                    pend_clr[1] = 1'b1;
                    r_nxt = launch(r_nxt, rup_pkg::CMD_VERSION, 1'b0, 1'b0, 64'h0,
                                   rup_pkg::PH_CMD);
                end
                else if (r.pend[2])
                begin
                    pend_clr[2] = 1'b1;
                    r_nxt = launch(r_nxt, rup_pkg::CMD_AUTH, 1'b0, 1'b0, w0_auth,
                                   rup_pkg::PH_CMD);
                end
                else if (r.pend[3])
                begin
                    pend_clr[3] = 1'b1;
                    r_nxt = launch(r_nxt, rup_pkg::CMD_PROG, 1'b0, 1'b0, w0_auth,
                                   rup_pkg::PH_CMD);
                end
                else if (r.pend[4])
                begin
                    pend_clr[4]     = 1'b1;
                    r_nxt.xfer_done = 1'b0;
                    r_nxt.auth_done = 1'b0;
                    r_nxt.auth_err  = ad_set ? r_nxt.auth_err : 16'h0000;
                    r_nxt.pkt_num   = 16'h0000;
                    r_nxt = launch(r_nxt, rup_pkg::CMD_CLEAR, 1'b0, 1'b0, 64'h0,
                                   rup_pkg::PH_CMD);
                end
            end
            rup_pkg::ST_SEND:
            begin
                // stall while the buffer is full, no word is dropped
                if (r.f_cnt != 2'h2)
                begin
                    push = 1'b1;
                    fin  = (r.widx == (r.pk_data ? rup_pkg::WORD_DATA_LAST
                                                 : rup_pkg::WORD_CTRL_LAST));
                    r_nxt.fifo[r.f_wr] = {(r.widx == 8'h00), fin, frame_word(r, mac_addr)};
                    r_nxt.f_wr         = ~r.f_wr;
                    r_nxt.widx         = 8'(r.widx + 8'h01);
                end
                if (fin)
                begin
                    case (r.phase)
                        rup_pkg::PH_REQ:
                        begin
                            r_nxt.st    = rup_pkg::ST_WAIT_ACK;
                            r_nxt.retry = 12'h000;
                        end
                        // second 1 KB half follows at once
                        rup_pkg::PH_DATA0:
                        begin
                            r_nxt.pkt_num = 16'(r.pkt_num + 16'h0001);
                            r_nxt = launch(r_nxt, rup_pkg::CMD_PAYLOAD, 1'b1, 1'b1, 64'h0,
                                           rup_pkg::PH_DATA1);
                        end
                        rup_pkg::PH_DATA1:
                        begin
                            r_nxt.pkt_num = 16'(r.pkt_num + 16'h0001);
                            if (r.last_r)
                            begin
                                r_nxt = launch(r_nxt, rup_pkg::CMD_CTRL, 1'b0, 1'b0,
                                               w0_auth, rup_pkg::PH_LAST);
                            end
                            else
                            begin
                                r_nxt.st     = rup_pkg::ST_IDLE;
                                r_nxt.done_p = 1'b1;
                            end
                        end
                        rup_pkg::PH_LAST:
                        begin
                            r_nxt.st     = rup_pkg::ST_IDLE;
                            r_nxt.done_p = 1'b1;
                        end
                        default:
                        begin
                            r_nxt.st = rup_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            rup_pkg::ST_WAIT_ACK:
            begin
                if (r.ack)
                begin
                    ack_clr = 1'b1;
                    r_nxt = launch(r_nxt, rup_pkg::CMD_PAYLOAD, 1'b1, 1'b0, 64'h0,
                                   rup_pkg::PH_DATA0);
                end
                else if (r.retry == 12'(RUP_RETRY_LAST))
                begin
                    r_nxt = launch(r_nxt, rup_pkg::CMD_CTRL, 1'b0, 1'b0, 64'h0,
                                   rup_pkg::PH_REQ);
                end
                else
                begin
                    r_nxt.retry = 12'(r.retry + 12'h001);
                end
            end
            default:
            begin
                r_nxt.st = rup_pkg::ST_IDLE;
            end
        endcase

        // set beats clear on the same edge
        r_nxt.pend  = (r.pend & ~pend_clr) | pend_set;
        r_nxt.ack   = (r.ack & ~ack_clr) | ack_set;
        r_nxt.f_cnt = 2'(r.f_cnt + {1'b0, push} - {1'b0, pop});
        // a reply landing with a clear still reports
        r_nxt.xfer_done = r_nxt.xfer_done | wd_set;
        r_nxt.auth_done = r_nxt.auth_done | ad_set;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // no FCS here, the MAC appends it
    assign tx_valid     = (r.f_cnt != 2'h0);
    assign tx_data      = r.fifo[r.f_rd][63:0];
    assign tx_eop       = r.fifo[r.f_rd][64];
    assign tx_sop       = r.fifo[r.f_rd][65];
    assign ser_rd_valid = r.rd_valid;
    assign ser_rd_data  = r.rd_data;
    assign cmd_irq      = r.irq;
    assign chunk_done   = r.done_p;

endmodule

/* File: dv/rup_initiator_asserts.sv */
// port assertions for the initiator
`timescale 1ns/100ps
module rup_initiator_asserts
(
    // watched ports
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        ser_wr_valid,
    input wire logic [7:0]  ser_wr_data,
    input wire logic        ser_rd_req,
    input wire logic        ser_rd_valid,
    input wire logic [31:0] ser_rd_data,
    input wire logic [4:0]  cmd_irq,
    input wire logic [47:0] mac_addr,
    input wire logic        tx_valid,
    input wire logic [63:0] tx_data,
    input wire logic        tx_sop,
    input wire logic        tx_eop,
    input wire logic        tx_ready
);
    logic [7:0]  wcnt_r;
    logic [15:0] cmd_r;
    wire         ok_code = ser_wr_data inside {[8'h01:8'h05]};
    // word index and command of the frame in flight
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            wcnt_r <= 8'h00;
        else if (tx_valid && tx_ready)
            wcnt_r <= tx_eop ? 8'h00 : wcnt_r + 8'h01;
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            cmd_r <= 16'h0000;
        else if (tx_valid && tx_ready && wcnt_r == 8'h01)
            cmd_r <= tx_data[15:0];
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    irq_match_a: assert property (
        ser_wr_valid && ok_code |=> cmd_irq == (5'h01 << ($past(ser_wr_data) - 8'h01)))
        else $error("irq does not match command");
    irq_quiet_a: assert property (
        !(ser_wr_valid && ok_code) |=> cmd_irq == 5'h00) else $error("irq without command");
    rd_answer_a: assert property (
        ser_rd_req |=> ser_rd_valid) else $error("read not answered");
    rd_quiet_a: assert property (
        !ser_rd_req |=> !ser_rd_valid && $stable(ser_rd_data)) else $error("read moved unasked");
    head_word_a: assert property (
        tx_valid && wcnt_r == 8'h00 |-> tx_sop && tx_data == {48'hFFFF_FFFF_FFFF, mac_addr[47:32]})
        else $error("bad first word");
    type_word_a: assert property (
        tx_valid && wcnt_r == 8'h01 |-> tx_data[63:16] == {mac_addr[31:0], 16'h0700})
        else $error("bad second word");
    len_word_a: assert property (
        tx_valid && wcnt_r == 8'h02 |-> tx_data == {32'h0,
        (cmd_r == 16'h0005 ? 16'h0400 : 16'h0040), 16'h0}) else $error("bad length word");
    frame_len_a: assert property (
        tx_valid && tx_eop |-> wcnt_r == (cmd_r == 16'h0005 ? 8'h82 : 8'h0A))
        else $error("bad frame length");
    zero_pay_a: assert property (
        tx_valid && wcnt_r > 8'h02 && cmd_r inside {16'h0009, 16'h000A} |-> tx_data == 64'h0)
        else $error("payload not zero");
    word_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("word lost");
    cover property (tx_valid && tx_eop && cmd_r == 16'h0005);
    cover property (tx_valid && !tx_ready);
    cover property (ser_rd_valid);
endmodule

bind rup_initiator rup_initiator_asserts chk_u (.clk(clk), .reset_n(reset_n),
    .ser_wr_valid(ser_wr_valid), .ser_wr_data(ser_wr_data), .ser_rd_req(ser_rd_req),
    .ser_rd_valid(ser_rd_valid), .ser_rd_data(ser_rd_data), .cmd_irq(cmd_irq),
    .mac_addr(mac_addr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_sop(tx_sop),
    .tx_eop(tx_eop), .tx_ready(tx_ready));

/* File: dv/rup_target_model.sv */
// behavioural remote target: captures frames, answers requests
`timescale 1ns/100ps
module rup_target_model
(
    // clock and behaviour controls
    input  wire logic        clk,
    input  wire logic        ack_en,
    input  wire logic        stall,
    input  wire logic        bad_type,
    input  wire logic [31:0] version,
    // frames from the initiator
    input  wire logic        tx_valid,
    input  wire logic [63:0] tx_data,
    input  wire logic        tx_eop,
    output logic             tx_ready = 1'b1,
    // replies toward the initiator
    output logic             rx_valid = 1'b0,
    output logic [63:0]      rx_data = 64'h0,
    output logic             rx_sop = 1'b0,
    output logic             rx_eop = 1'b0
);
    logic [63:0] w [0:3];
    logic [15:0] rc;
    int          n = 0;
    int          nw = 0;
    int          frames = 0;
    int          req_n = 0;
    int          done_n = 0;
    always @(posedge clk)
        tx_ready <= stall ? ~tx_ready : 1'b1;
    always @(posedge clk)
        if (tx_valid && tx_ready)
        begin
            if (n < 4)
                w[n] <= tx_data;
            n <= tx_eop ? 0 : n + 1;
            if (tx_eop)
            begin
                nw <= n + 1;
                frames <= frames + 1;
                req_n <= req_n + 1;
                // transfer request answered only when allowed
                case (w[1][15:0])
                    16'h0004: rc <= (ack_en && w[3] == 64'h0) ? 16'h0004 : 16'h0;
                    16'h0007: rc <= 16'h0002;
                    16'h0008, 16'h0009: rc <= 16'h0003;
                    // each data frame answered with write complete
                    16'h0005: rc <= 16'h0001;
                    default: rc <= 16'h0;
                endcase
            end
        end
    // idle data toggles so a stale word never looks valid
    initial
        forever
        begin
            @(posedge clk);
            #1;
            rx_data = ~rx_data;
            if (req_n != done_n)
            begin
                done_n = done_n + 1;
                for (int i = 0; i < 4 && rc != 16'h0; i++)
                begin
                    rx_valid = 1'b1;
                    rx_sop = (i == 0);
                    rx_eop = (i == 3);
                    rx_data = (i == 1) ? {32'h0, bad_type ? 16'h0701 : 16'h0700, rc} :
                              (i == 3) ? {version, 16'h0, version[15:0]} : 64'h0;
                    @(posedge clk);
                    #1;
                end
                rx_valid = 1'b0;
                rx_sop = 1'b0;
                rx_eop = 1'b0;
            end
        end
endmodule

/* File: dv/tb_rup_initiator.sv */
// self-checking bench for the initiator
`timescale 1ns/100ps
module tb_rup_initiator;
    logic        clk, reset_n = 1'b0, ser_wr_valid = 1'b0, ser_rd_req = 1'b0;
    logic        buf_wr_en = 1'b0, chunk_ready = 1'b0, chunk_last = 1'b0;
    logic        ack_en = 1'b0, stall = 1'b0, bad_type = 1'b0;
    logic [7:0]  ser_wr_data = 8'h00, buf_wr_addr = 8'h00;
    logic [1:0]  ser_rd_sel = 2'h0;
    logic [63:0] buf_wr_data = 64'h0;
    logic [15:0] last_size = 16'h0;
    logic [31:0] version = 32'h1234_5678, ser_rd_data;
    logic [63:0] tx_data, rx_data;
    logic [4:0]  cmd_irq;
    logic        ser_rd_valid, chunk_done, tx_valid, tx_sop, tx_eop, tx_ready;
    logic        rx_valid, rx_sop, rx_eop;
    int          fails = 0, checks_done = 0, cyc = 0, done_cnt = 0;
    rup_initiator dut_u (.clk(clk), .reset_n(reset_n), .ser_wr_valid(ser_wr_valid),
        .ser_wr_data(ser_wr_data), .ser_rd_req(ser_rd_req), .ser_rd_sel(ser_rd_sel),
        .ser_rd_valid(ser_rd_valid), .ser_rd_data(ser_rd_data), .cmd_irq(cmd_irq),
        .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data),
        .chunk_ready(chunk_ready), .chunk_last(chunk_last), .last_size(last_size),
        .chunk_done(chunk_done), .mac_addr(48'hA1B2_C3D4_E5F6), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_sop(rx_sop), .rx_eop(rx_eop));
    rup_target_model model_u (.clk(clk), .ack_en(ack_en), .stall(stall),
        .bad_type(bad_type), .version(version), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_eop(tx_eop), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_sop(rx_sop), .rx_eop(rx_eop));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // pulse counted mid-cycle, away from the edge that launches it
    always @(negedge clk)
        done_cnt += int'(chunk_done === 1'b1);
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic user_cmd(input logic [7:0] code, input logic [4:0] irq);
        ser_wr_valid = 1'b1;
        ser_wr_data = code;
        tick(1);
        ser_wr_valid = 1'b0;
        chk("irq", 64'(irq), 64'(cmd_irq));
        tick(1);
    endtask
    task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
        ser_rd_req = 1'b1;
        ser_rd_sel = sel;
        tick(1);
        ser_rd_req = 1'b0;
        chk("rd_valid", 64'h1, 64'(ser_rd_valid));
        chk("rd_data", 64'(exp), 64'(ser_rd_data));
        tick(1);
    endtask
    task automatic frame(input logic [15:0] cmd, input int words, input logic [63:0] pay);
        int f;
        f = model_u.frames;
        for (int k = 0; k < 3000 && model_u.frames == f; k++)
            tick(1);
        chk("frames", 64'(f + 1), 64'(model_u.frames));
        chk("cmd", 64'(cmd), 64'(model_u.w[1][15:0]));
        chk("words", 64'(words), 64'(model_u.nw));
        chk("pay", pay, model_u.w[3]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_chunk;
        user_cmd(8'h01, 5'h01);
        // whole 2 KB chunk loaded before ready
        for (int k = 0; k < 256; k++)
        begin
            buf_wr_en = 1'b1;
            buf_wr_addr = 8'(k);
            buf_wr_data = {56'hA5, 8'(k)};
            tick(1);
        end
        buf_wr_en = 1'b0;
        chunk_last = 1'b1;
        last_size = 16'h0123;
        chunk_ready = 1'b1;
        tick(1);
        chunk_ready = 1'b0;
        frame(16'h0004, 11, 64'h0);
        frame(16'h0004, 11, 64'h0);
        ack_en = 1'b1;
        stall = 1'b1;
        frame(16'h0004, 11, 64'h0);
        frame(16'h0005, 131, {56'hA5, 8'h00});
        frame(16'h0005, 131, {56'hA5, 8'h80});
        frame(16'h0004, 11, {16'h0, 16'h0123, 31'h0, 1'b1});
        stall = 1'b0;
        chk("done", 64'h1, 64'(done_cnt));
        rd(2'h2, 32'h2);
        rd(2'h0, 32'h1);
    endtask
    initial
    begin
        tick(10);
        reset_n = 1'b1;
        chk("tx_valid", 64'h0, 64'(tx_valid));
        user_cmd(8'h06, 5'h00);
        user_cmd(8'h02, 5'h02);
        frame(16'h0009, 11, 64'h0);
        chk("dest", {48'hFFFF_FFFF_FFFF, 16'hA1B2}, model_u.w[0]);
        chk("len", {32'h0, 16'h0040, 16'h0}, model_u.w[2]);
        tick(20);
        rd(2'h3, 32'h1234_5678);
        bad_type = 1'b1;
        version = 32'h0BAD_0BAD;
        user_cmd(8'h02, 5'h02);
        frame(16'h0009, 11, 64'h0);
        tick(20);
        rd(2'h3, 32'h1234_5678);
        bad_type = 1'b0;
        t_chunk();
        user_cmd(8'h03, 5'h04);
        frame(16'h0007, 11, {16'h0, 16'h0123, 31'h0, 1'b1});
        tick(20);
        rd(2'h1, 32'h0BAD_0001);
        version = 32'h0002_0003;
        user_cmd(8'h04, 5'h08);
        frame(16'h0008, 11, {16'h0, 16'h0123, 31'h0, 1'b1});
        tick(20);
        rd(2'h3, 32'h0002_0003);
        user_cmd(8'h05, 5'h10);
        frame(16'h000A, 11, 64'h0);
        rd(2'h2, 32'h0);
        rd(2'h0, 32'h0);
        conclude();
    end
endmodule
